// ---- pfs_defines.vh ----
// constants for the pin function select block
`ifndef PFS_DEFINES_VH
`define PFS_DEFINES_VH

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define PFS_ADDR_W             4
`define PFS_SYSCFG_ADDR        4'h0
`define PFS_STATUS_ADDR        4'h4
`define PFS_SYSCFG_RESET       32'h00000000
`define PFS_SYSCFG_MASK        32'h3FFFFFFF

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define PFS_BIT_FLAG0_IRQ      16
`define PFS_BIT_FLAG1_IRQ      17
`define PFS_BIT_GENERAL_PIN_TWO_IRQ      18
`define PFS_BIT_GENERAL_PIN_THREE_TMR      19
`define PFS_BIT_PP_DISABLE     20
`define PFS_BIT_SERIAL_FLAG    21
`define PFS_BIT_FLAG_B         22
`define PFS_BIT_FLAG_C         23
`define PFS_BIT_FLAG_LOW       24
`define PFS_BIT_FLAG_A         25
`define PFS_BIT_PULSE_B        26
`define PFS_BIT_PULSE_C        27
`define PFS_BIT_PULSE_LOW      28
`define PFS_BIT_PULSE_A        29

// ---------------------------------------------------------------
// nibble group modes
// ---------------------------------------------------------------
`define PFS_MODE_PORT          2'h0
`define PFS_MODE_FLAG          2'h1
`define PFS_MODE_PULSE         2'h2

`endif

// ---- pfs_group_mux.v ----
// one four-pin address/data group: port, flag or pulse role
`timescale 1ns/10ps
`include "pfs_defines.vh"
module pfs_group_mux (
   input  wire [1:0] mode_in,
   input  wire [3:0] port_out_in,
   input  wire [3:0] port_oe_n_in,
   input  wire [3:0] flag_out_in,
   input  wire [3:0] flag_oe_n_in,
   input  wire [3:0] pulse_in,
   output reg  [3:0] pin_out,
   output reg  [3:0] pin_oe_n_out
);
   always @* begin
      case (mode_in)
         `PFS_MODE_FLAG: begin
            pin_out      = flag_out_in;
            pin_oe_n_out = flag_oe_n_in;
         end
         `PFS_MODE_PULSE: begin
            pin_out      = pulse_in;
            pin_oe_n_out = 4'h0;
         end
         default: begin
            pin_out      = port_out_in;
            pin_oe_n_out = port_oe_n_in;
         end
      endcase
   end
endmodule // pfs_group_mux

// ---- pfs_pin_function_select.v ----
// system configuration register and shared pin role selection
//
// Contract
// - bit 18: flag two becomes interrupt two
// - bit 19: flag three outputs timer expiry
// - bit 20 set disables parallel port
// - disabled port plus group bits: flag pins
// - sixteen flags: original flags take alternates
// - bit 21: serial 4/5 pins flag mode
// - bit 22: pins 11-8 flag mode
// - bit 23: pins 15-12 flag mode
// - bit 24: pins 3-0 flag mode
// - bit 25: pins 7-4 flag mode
// - bit 26: pins 11-8 pulse outputs
// - bit 27: pins 15-12 pulse outputs
// - bit 28: pins 3-0 pulse outputs
// - bit 29: pins 7-4 pulse outputs
// - register resets to all zeros
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "pfs_defines.vh"
module pfs_pin_function_select (
   input  wire                   mclk_in,
   input  wire                   rst_in,
   // ---------------------------------------------------------------
   // register port
   // ---------------------------------------------------------------
   input  wire [`PFS_ADDR_W-1:0] addr_in,
   input  wire [31:0]            wdata_in,
   input  wire                   wr_in,
   input  wire                   rd_in,
   output reg  [31:0]            rdata_out,
   // ---------------------------------------------------------------
   // parallel port side
   // ---------------------------------------------------------------
   output reg                    port_enable_out,
   input  wire [15:0]            port_ad_in,
   input  wire [15:0]            port_ad_oe_n_in,
   output reg  [15:0]            port_ad_out,
   // ---------------------------------------------------------------
   // flag, pulse, interrupt and timer sources
   // ---------------------------------------------------------------
   input  wire [15:0]            flag_ad_in,
   input  wire [15:0]            flag_ad_oe_n_in,
   output reg  [15:0]            flag_ad_out,
   input  wire [15:0]            pulse_ad_in,
   input  wire [3:0]             gp_flag_in,
   input  wire [3:0]             gp_flag_oe_n_in,
   output reg  [3:0]             gp_flag_out,
   input  wire                   timer_expired_in,
   output reg  [2:0]             interrupt_request_out,
   output reg                    serial_pins_flag_select_out,
   // ---------------------------------------------------------------
   // shared pins
   // ---------------------------------------------------------------
   input  wire [15:0]            ad_pin_in,
   output reg  [15:0]            ad_pin_out,
   output reg  [15:0]            ad_pin_oe_n_out,
   input  wire [3:0]             flag_pin_in,
   output reg  [3:0]             flag_pin_out,
   output reg  [3:0]             flag_pin_oe_n_out
);

   // ---------------------------------------------------------------
   // register decode
   // ---------------------------------------------------------------
   // only the configuration word is writable; a store to any other
   // address is dropped so a stray write cannot reshuffle the pins
   wire        cfg_write;
   wire        cfg_read;
   wire        status_read;
   assign cfg_write   = wr_in && (addr_in == `PFS_SYSCFG_ADDR);
   assign cfg_read    = rd_in && (addr_in == `PFS_SYSCFG_ADDR);
   assign status_read = rd_in && (addr_in == `PFS_STATUS_ADDR);

   // ---------------------------------------------------------------
   // configuration register
   // ---------------------------------------------------------------
   reg  [31:0] system_configuration;

   always @(posedge mclk_in) begin
      if (rst_in) begin
         system_configuration <= `PFS_SYSCFG_RESET;
      end else if (cfg_write) begin
         system_configuration <= wdata_in & `PFS_SYSCFG_MASK;
      end
   end

   wire flag_two_interrupt_select        = system_configuration[`PFS_BIT_GENERAL_PIN_TWO_IRQ];
   wire flag_three_timeout_output_select = system_configuration[`PFS_BIT_GENERAL_PIN_THREE_TMR];
   wire parallel_port_disable            = system_configuration[`PFS_BIT_PP_DISABLE];
   wire [3:0] group_flag_select = {system_configuration[`PFS_BIT_FLAG_C],
                                   system_configuration[`PFS_BIT_FLAG_B],
                                   system_configuration[`PFS_BIT_FLAG_A],
                                   system_configuration[`PFS_BIT_FLAG_LOW]};
   wire [3:0] group_pulse_select = {system_configuration[`PFS_BIT_PULSE_C],
                                    system_configuration[`PFS_BIT_PULSE_B],
                                    system_configuration[`PFS_BIT_PULSE_A],
                                    system_configuration[`PFS_BIT_PULSE_LOW]};

   // ---------------------------------------------------------------
   // group modes, index 0 = pins 3-0 up to 3 = pins 15-12
   // ---------------------------------------------------------------
   // flag role needs the port disabled; pulse takes precedence so a
   // group never sees two drivers
   function [1:0] group_mode;
      input flag_sel;
      input pulse_sel;
      input pp_dis;
      begin
         if (pulse_sel)
            group_mode = `PFS_MODE_PULSE;
         else if (flag_sel && pp_dis)
            group_mode = `PFS_MODE_FLAG;
         else
            group_mode = `PFS_MODE_PORT;
      end
   endfunction

   wire [1:0] mode_low = group_mode(group_flag_select[0], group_pulse_select[0],
                                    parallel_port_disable);
   wire [1:0] mode_a   = group_mode(group_flag_select[1], group_pulse_select[1],
                                    parallel_port_disable);
   wire [1:0] mode_b   = group_mode(group_flag_select[2], group_pulse_select[2],
                                    parallel_port_disable);
   wire [1:0] mode_c   = group_mode(group_flag_select[3], group_pulse_select[3],
                                    parallel_port_disable);

   // all four groups in flag mode form the sixteen flags
   wire sixteen_flags = (mode_low == `PFS_MODE_FLAG) && (mode_a == `PFS_MODE_FLAG) &&
                        (mode_b == `PFS_MODE_FLAG) && (mode_c == `PFS_MODE_FLAG);

   // ---------------------------------------------------------------
   // address/data pin muxing
   // ---------------------------------------------------------------
   wire [15:0] next_ad_pin;
   wire [15:0] next_ad_oe_n;

   pfs_group_mux u_grp_low (
      .mode_in      (mode_low),
      .port_out_in  (port_ad_in[3:0]),
      .port_oe_n_in (port_ad_oe_n_in[3:0]),
      .flag_out_in  (flag_ad_in[3:0]),
      .flag_oe_n_in (flag_ad_oe_n_in[3:0]),
      .pulse_in     (pulse_ad_in[3:0]),
      .pin_out      (next_ad_pin[3:0]),
      .pin_oe_n_out (next_ad_oe_n[3:0])
   );
   pfs_group_mux u_grp_a (
      .mode_in      (mode_a),
      .port_out_in  (port_ad_in[7:4]),
      .port_oe_n_in (port_ad_oe_n_in[7:4]),
      .flag_out_in  (flag_ad_in[7:4]),
      .flag_oe_n_in (flag_ad_oe_n_in[7:4]),
      .pulse_in     (pulse_ad_in[7:4]),
      .pin_out      (next_ad_pin[7:4]),
      .pin_oe_n_out (next_ad_oe_n[7:4])
   );
   pfs_group_mux u_grp_b (
      .mode_in      (mode_b),
      .port_out_in  (port_ad_in[11:8]),
      .port_oe_n_in (port_ad_oe_n_in[11:8]),
      .flag_out_in  (flag_ad_in[11:8]),
      .flag_oe_n_in (flag_ad_oe_n_in[11:8]),
      .pulse_in     (pulse_ad_in[11:8]),
      .pin_out      (next_ad_pin[11:8]),
      .pin_oe_n_out (next_ad_oe_n[11:8])
   );
   pfs_group_mux u_grp_c (
      .mode_in      (mode_c),
      .port_out_in  (port_ad_in[15:12]),
      .port_oe_n_in (port_ad_oe_n_in[15:12]),
      .flag_out_in  (flag_ad_in[15:12]),
      .flag_oe_n_in (flag_ad_oe_n_in[15:12]),
      .pulse_in     (pulse_ad_in[15:12]),
      .pin_out      (next_ad_pin[15:12]),
      .pin_oe_n_out (next_ad_oe_n[15:12])
   );

   // ---------------------------------------------------------------
   // pin input synchronisers
   // ---------------------------------------------------------------
   wire [15:0] ad_sync;
   wire [3:0]  flag_sync;

   pfs_sync2 #(.W(16)) u_sync_ad (
      .mclk_in (mclk_in),
      .rst_in  (rst_in),
      .d_in    (ad_pin_in),
      .q_out   (ad_sync)
   );
   pfs_sync2 #(.W(4)) u_sync_flag (
      .mclk_in (mclk_in),
      .rst_in  (rst_in),
      .d_in    (flag_pin_in),
      .q_out   (flag_sync)
   );

   // ---------------------------------------------------------------
   // original flag pin roles
   // ---------------------------------------------------------------
   // alternate role per pin: 0..2 interrupt input, 3 timer output;
   // the sixteen-flag setup overrides the per-pin bits so the two
   // uses of one pin can never be selected at once
   wire       flag_zero_interrupt_select = system_configuration[`PFS_BIT_FLAG0_IRQ];
   wire       flag_one_interrupt_select  = system_configuration[`PFS_BIT_FLAG1_IRQ];
   wire [3:0] flag_alt;
   assign flag_alt[0] = flag_zero_interrupt_select | sixteen_flags;
   assign flag_alt[1] = flag_one_interrupt_select | sixteen_flags;
   assign flag_alt[2] = flag_two_interrupt_select | sixteen_flags;
   assign flag_alt[3] = flag_three_timeout_output_select | sixteen_flags;

   // group masks for what reaches each consumer
   wire [15:0] port_mask;
   wire [15:0] flag_mask;
   assign port_mask = {{4{mode_c == `PFS_MODE_PORT}}, {4{mode_b == `PFS_MODE_PORT}},
                       {4{mode_a == `PFS_MODE_PORT}}, {4{mode_low == `PFS_MODE_PORT}}};
   assign flag_mask = {{4{mode_c == `PFS_MODE_FLAG}}, {4{mode_b == `PFS_MODE_FLAG}},
                       {4{mode_a == `PFS_MODE_FLAG}}, {4{mode_low == `PFS_MODE_FLAG}}};

   // ---------------------------------------------------------------
   // synchronised pin readback
   // ---------------------------------------------------------------
   // a group in pulse role reads back as zero on both paths, because
   // neither the port nor the flag controller owns its pins then
   reg  [15:0] next_port_ad;
   reg  [15:0] next_flag_ad;
   reg  [3:0]  next_gp_flag;
   reg  [2:0]  next_interrupt;

   always @* begin
      next_port_ad   = ad_sync & port_mask;
      next_flag_ad   = ad_sync & flag_mask;
      next_gp_flag   = flag_sync & ~flag_alt;
      next_interrupt = flag_sync[2:0] & flag_alt[2:0];
   end

   // ---------------------------------------------------------------
   // original flag pin drive
   // ---------------------------------------------------------------
   // interrupt pins are released so the outside source can drive them;
   // the timer pin is always driven while it carries the expiry level
   reg  [3:0]  next_flag_pin;
   reg  [3:0]  next_flag_oe_n;

   always @* begin
      next_flag_pin[2:0]  = gp_flag_in[2:0];
      next_flag_oe_n[2:0] = gp_flag_oe_n_in[2:0] | flag_alt[2:0];
      if (flag_alt[3]) begin
         next_flag_pin[3]  = timer_expired_in;
         next_flag_oe_n[3] = 1'b0;
      end else begin
         next_flag_pin[3]  = gp_flag_in[3];
         next_flag_oe_n[3] = gp_flag_oe_n_in[3];
      end
   end

   // ---------------------------------------------------------------
   // status word
   // ---------------------------------------------------------------
   // read-only view of the decoded roles, so software can see the
   // outcome of the precedence rules without probing the pins
   wire [31:0] status_word;
   assign status_word[1:0]   = mode_low;
   assign status_word[3:2]   = mode_a;
   assign status_word[5:4]   = mode_b;
   assign status_word[7:6]   = mode_c;
   assign status_word[8]     = 1'b0;
   assign status_word[9]     = sixteen_flags;
   assign status_word[13:10] = flag_sync;
   assign status_word[31:14] = 18'h00000;

   // ---------------------------------------------------------------
   // registered control outputs
   // ---------------------------------------------------------------
   // the enable is the inverse of the disable bit, so the port is live
   // straight out of reset
   always @(posedge mclk_in) begin
      if (rst_in) begin
         port_enable_out             <= 1'b1;
         serial_pins_flag_select_out <= 1'b0;
      end else begin
         port_enable_out             <= ~parallel_port_disable;
         serial_pins_flag_select_out <= system_configuration[`PFS_BIT_SERIAL_FLAG];
      end
   end

   // ---------------------------------------------------------------
   // registered pin outputs
   // ---------------------------------------------------------------
   // one register stage on all pin paths keeps outputs glitch free at
   // the cost of one cycle of latency
   always @(posedge mclk_in) begin
      if (rst_in) begin
         ad_pin_out        <= 16'h0000;
         ad_pin_oe_n_out   <= 16'hFFFF;
         flag_pin_out      <= 4'h0;
         flag_pin_oe_n_out <= 4'hF;
      end else begin
         ad_pin_out        <= next_ad_pin;
         ad_pin_oe_n_out   <= next_ad_oe_n;
         flag_pin_out      <= next_flag_pin;
         flag_pin_oe_n_out <= next_flag_oe_n;
      end
   end

   // ---------------------------------------------------------------
   // registered readback outputs
   // ---------------------------------------------------------------
   // pin levels pass the synchronisers first, so a pin change shows
   // here three edges later
   always @(posedge mclk_in) begin
      if (rst_in) begin
         port_ad_out           <= 16'h0000;
         flag_ad_out           <= 16'h0000;
         gp_flag_out           <= 4'h0;
         interrupt_request_out <= 3'h0;
      end else begin
         port_ad_out           <= next_port_ad;
         flag_ad_out           <= next_flag_ad;
         gp_flag_out           <= next_gp_flag;
         interrupt_request_out <= next_interrupt;
      end
   end

   // ---------------------------------------------------------------
   // register read
   // ---------------------------------------------------------------
   // data stand for exactly one cycle; idle cycles and unmapped
   // addresses return zero
   always @(posedge mclk_in) begin
      if (rst_in) begin
         rdata_out <= 32'h00000000;
      end else if (cfg_read) begin
         rdata_out <= system_configuration;
      end else if (status_read) begin
         rdata_out <= status_word;
      end else begin
         rdata_out <= 32'h00000000;
      end
   end

endmodule // pfs_pin_function_select

// ---- pfs_pin_function_select_bench.sv ----
// self-checking bench for the pin function select block
`timescale 1ns/10ps
`include "pfs_defines.vh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; $display("mismatch %0t got %h exp %h", $time, a, b); end end
module pfs_pin_function_select_bench;
   logic        mclk_in = 0, rst_in = 1, wr_in = 0, rd_in = 0, timer_expired_in = 0;
   logic [3:0]  addr_in = 0, gp_flag_in = 0, gp_flag_oe_n_in = 4'hF, flag_ext = 0;
   logic [31:0] wdata_in = 0, rdata_out, c, e;
   logic [15:0] port_ad_in = 0, port_ad_oe_n_in = 16'hFFFF, flag_ad_in = 0, pulse_ad_in = 0;
   logic [15:0] flag_ad_oe_n_in = 16'hFFFF, ad_ext = 0, ad_pin_in, ad_pin_out, ad_pin_oe_n_out;
   logic [15:0] port_ad_out, flag_ad_out;
   logic [3:0]  gp_flag_out, flag_pin_in, flag_pin_out, flag_pin_oe_n_out;
   logic [2:0]  interrupt_request_out;
   logic        port_enable_out, serial_pins_flag_select_out;
   logic [7:0]  m;
   logic [3:0]  alt, rl, dv, lv;
   logic [15:0] pm, fm, la;
   logic        sx;
   integer      seed = 32'hB437, errors = 0, samples_checked = 0;
   always #10 mclk_in = ~mclk_in;
   pfs_pin_function_select pfs_pin_function_select_i (.mclk_in, .rst_in, .addr_in, .wdata_in,
      .wr_in, .rd_in, .rdata_out, .port_enable_out, .port_ad_in, .port_ad_oe_n_in, .port_ad_out,
      .flag_ad_in, .flag_ad_oe_n_in, .flag_ad_out, .pulse_ad_in, .gp_flag_in, .gp_flag_oe_n_in,
      .gp_flag_out, .timer_expired_in, .interrupt_request_out, .serial_pins_flag_select_out,
      .ad_pin_in, .ad_pin_out, .ad_pin_oe_n_out, .flag_pin_in, .flag_pin_out, .flag_pin_oe_n_out);
   pfs_pin_model pfs_pin_model_i (.ad_drive_in(ad_pin_out), .ad_oe_n_in(ad_pin_oe_n_out),
      .ad_ext_in(ad_ext), .ad_level_out(ad_pin_in), .flag_drive_in(flag_pin_out),
      .flag_oe_n_in(flag_pin_oe_n_out), .flag_ext_in(flag_ext), .flag_level_out(flag_pin_in));
   // expected {drive enables, pin data}: pulse beats flag, flag needs the port disabled
   function automatic logic [31:0] expect_pins(input logic [31:0] v);
      int fb[4] = '{24, 25, 22, 23};
      logic [31:0] r;
      for (int g = 0; g < 4; g++) begin
         r[g*4+:4] = v[fb[g]+4] ? pulse_ad_in[g*4+:4] :
                     (v[20] && v[fb[g]]) ? flag_ad_in[g*4+:4] : port_ad_in[g*4+:4];
         r[16+g*4+:4] = v[fb[g]+4] ? 4'h0 :
                        (v[20] && v[fb[g]]) ? flag_ad_oe_n_in[g*4+:4] : port_ad_oe_n_in[g*4+:4];
      end
      return r;
   endfunction
   // expected role per group: 2 pulse, 1 flag, 0 port
   function automatic logic [7:0] group_roles(input logic [31:0] v);
      logic [7:0] r;
      int         f;
      for (int g = 0; g < 4; g++) begin
         f = (g < 2) ? 24 + g : 20 + g;
         r[g*2+:2] = v[f+4] ? 2'h2 : (v[20] && v[f]) ? 2'h1 : 2'h0;
      end
      return r;
   endfunction
   task wr(input logic [3:0] a, input logic [31:0] d);
      addr_in <= a; wdata_in <= d; wr_in <= 1'b1;
      @(posedge mclk_in);
      wr_in <= 1'b0;
   endtask
   task rd(input logic [3:0] a, input logic [31:0] x);
      addr_in <= a; rd_in <= 1'b1;
      @(posedge mclk_in);
      rd_in <= 1'b0;
      #1 `CHK(rdata_out, x)
   endtask
   task give_verdict;
      if (errors == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge mclk_in);
      rst_in <= 1'b0;
      rd(`PFS_SYSCFG_ADDR, `PFS_SYSCFG_RESET);
      `CHK(port_enable_out, 1'b1)
      for (int i = 0; i < 64; i++) begin
         c = $random(seed);
         // every fourth pass: all four groups in flag mode, no pulse
         if (i % 4 == 0) c = (c & ~32'h3C000000) | 32'h03D00000;
         {port_ad_in, port_ad_oe_n_in} <= $random(seed);
         {flag_ad_in, flag_ad_oe_n_in} <= $random(seed);
         {pulse_ad_in, ad_ext} <= $random(seed);
         {gp_flag_in, gp_flag_oe_n_in, flag_ext, timer_expired_in} <= 13'($random(seed));
         wr(`PFS_SYSCFG_ADDR, c);
         rd(`PFS_SYSCFG_ADDR, c & `PFS_SYSCFG_MASK);
         repeat (4) @(posedge mclk_in);
         #1 e = expect_pins(c);
         `CHK(ad_pin_out, e[15:0])
         `CHK(ad_pin_oe_n_out, e[31:16])
         `CHK(port_enable_out, !c[20])
         `CHK(serial_pins_flag_select_out, c[21])
         if (c[18]) `CHK(gp_flag_out[2], 1'b0)
         if (c[19]) `CHK(flag_pin_out[3], timer_expired_in)
         m = group_roles(c);
         sx = (m == 8'h55);
         if (i % 4 == 0) `CHK({gp_flag_out, flag_pin_out[3]}, {4'h0, timer_expired_in})
         else if (!c[16] && !sx) `CHK(gp_flag_out[0], flag_pin_in[0])
         for (int g = 0; g < 4; g++) begin
            pm[g*4+:4] = {4{m[g*2+:2] == 2'h0}};
            fm[g*4+:4] = {4{m[g*2+:2] == 2'h1}};
         end
         la = (e[15:0] & ~e[31:16]) | (ad_ext & e[31:16]);
         `CHK(port_ad_out, la & pm)
         `CHK(flag_ad_out, la & fm)
         alt = c[19:16] | {4{sx}};
         rl = {!alt[3] && gp_flag_oe_n_in[3], gp_flag_oe_n_in[2:0] | alt[2:0]};
         dv = {alt[3] ? timer_expired_in : gp_flag_in[3], gp_flag_in[2:0]};
         lv = (dv & ~rl) | (flag_ext & rl);
         `CHK(flag_pin_out, dv)
         `CHK(flag_pin_oe_n_out, rl)
         `CHK(gp_flag_out, lv & ~alt)
         `CHK(interrupt_request_out, lv[2:0] & alt[2:0])
         rd(`PFS_STATUS_ADDR, {18'h00000, lv, sx, 1'b0, m});
      end
      wr(4'h8, 32'hFFFFFFFF);
      rd(`PFS_SYSCFG_ADDR, c & `PFS_SYSCFG_MASK);
      rd(4'hC, 32'h0);
      rst_in <= 1'b1;
      repeat (2) @(posedge mclk_in);
      rst_in <= 1'b0;
      #1 `CHK({ad_pin_oe_n_out, flag_pin_oe_n_out, port_enable_out}, {16'hFFFF, 4'hF, 1'b1})
      rd(`PFS_SYSCFG_ADDR, `PFS_SYSCFG_RESET);
      give_verdict;
   end
   initial begin
      #100000;
      errors++;
      give_verdict;
   end
endmodule // pfs_pin_function_select_bench

// ---- pfs_pin_function_select_checker.sv ----
// assertion checker for the pin function select block
`timescale 1ns/10ps
`include "pfs_defines.vh"
module pfs_pin_function_select_checker (
   input logic        mclk_in,
   input logic        rst_in,
   input logic [3:0]  addr_in,
   input logic [31:0] wdata_in,
   input logic        wr_in,
   input logic        rd_in,
   input logic [31:0] rdata_out,
   input logic        port_enable_out,
   input logic [15:0] port_ad_in,
   input logic [15:0] port_ad_oe_n_in,
   input logic [15:0] flag_ad_in,
   input logic [15:0] flag_ad_oe_n_in,
   input logic [15:0] pulse_ad_in,
   input logic        timer_expired_in,
   input logic [3:0]  gp_flag_out,
   input logic        serial_pins_flag_select_out,
   input logic [15:0] ad_pin_out,
   input logic [15:0] ad_pin_oe_n_out,
   input logic [3:0]  flag_pin_out,
   input logic [3:0]  flag_pin_oe_n_out
);
   logic [31:0] sh;
   logic [15:0] e_out;
   logic [15:0] e_oe;
   wire  [3:0]  fl = {sh[23], sh[22], sh[25], sh[24]} & {4{sh[20]}};
   wire  [3:0]  pl = {sh[27], sh[26], sh[29], sh[28]};
   wire  [3:0]  fm = fl & ~pl;
   // shadow of the config register and the registered group mux
   always @(posedge mclk_in) begin
      if (rst_in)
         sh <= `PFS_SYSCFG_RESET;
      else if (wr_in && addr_in == `PFS_SYSCFG_ADDR)
         sh <= wdata_in & `PFS_SYSCFG_MASK;
      for (int g = 0; g < 4; g++) begin
         e_out[g*4+:4] <= pl[g] ? pulse_ad_in[g*4+:4] :
                          fl[g] ? flag_ad_in[g*4+:4] : port_ad_in[g*4+:4];
         e_oe[g*4+:4]  <= pl[g] ? 4'h0 :
                          fl[g] ? flag_ad_oe_n_in[g*4+:4] : port_ad_oe_n_in[g*4+:4];
      end
   end
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   chk_config_readback: assert property (
      rd_in && addr_in == `PFS_SYSCFG_ADDR |=> rdata_out == $past(sh)) else $error("bad readback");
   chk_reset_drive: assert property (
      $past(rst_in) |-> ad_pin_oe_n_out == 16'hFFFF && flag_pin_oe_n_out == 4'hF)
      else $error("pins driven after reset");
   chk_port_enable: assert property (
      !$past(rst_in) |-> port_enable_out == !$past(sh[20])) else $error("bad port enable");
   chk_serial_select: assert property (
      !$past(rst_in) |-> serial_pins_flag_select_out == $past(sh[21]))
      else $error("bad serial select");
   chk_flag_two_role: assert property (
      !$past(rst_in) && $past(sh[18]) |-> gp_flag_out[2] == 1'b0) else $error("flag two gpio");
   chk_flag_two_release: assert property (
      !$past(rst_in) && $past(sh[18]) |-> flag_pin_oe_n_out[2]) else $error("flag two driven");
   chk_timer_output: assert property (
      !$past(rst_in) && $past(sh[19] || &fm) |->
      flag_pin_out[3] == $past(timer_expired_in) && !flag_pin_oe_n_out[3])
      else $error("timer output wrong");
   chk_sixteen_flags: assert property (
      !$past(rst_in) && $past(&fm) |-> gp_flag_out == 4'h0) else $error("flags not alternate");
   chk_group_data: assert property (
      !$past(rst_in) |-> ad_pin_out == e_out) else $error("group pin data wrong");
   chk_group_drive: assert property (
      !$past(rst_in) |-> ad_pin_oe_n_out == e_oe) else $error("group pin drive wrong");
endmodule // pfs_pin_function_select_checker
bind pfs_pin_function_select pfs_pin_function_select_checker pfs_pin_function_select_checker_i (
   .mclk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .port_enable_out,
   .port_ad_in, .port_ad_oe_n_in, .flag_ad_in, .flag_ad_oe_n_in, .pulse_ad_in,
   .timer_expired_in, .gp_flag_out, .serial_pins_flag_select_out, .ad_pin_out,
   .ad_pin_oe_n_out, .flag_pin_out, .flag_pin_oe_n_out);

// ---- pfs_pin_model.sv ----
// external pin levels seen by the block
`timescale 1ns/10ps
module pfs_pin_model (
   input  logic [15:0] ad_drive_in,
   input  logic [15:0] ad_oe_n_in,
   input  logic [15:0] ad_ext_in,
   output logic [15:0] ad_level_out,
   input  logic [3:0]  flag_drive_in,
   input  logic [3:0]  flag_oe_n_in,
   input  logic [3:0]  flag_ext_in,
   output logic [3:0]  flag_level_out
);
   // released pins follow the outside circuit, so stale drive never lingers
   assign ad_level_out   = (ad_drive_in & ~ad_oe_n_in) | (ad_ext_in & ad_oe_n_in);
   assign flag_level_out = (flag_drive_in & ~flag_oe_n_in) | (flag_ext_in & flag_oe_n_in);
endmodule // pfs_pin_model

// ---- pfs_sync2.v ----
// two-stage synchroniser for a bus of pin inputs
`timescale 1ns/10ps
module pfs_sync2 #(
   parameter W = 16
) (
   input  wire         mclk_in,
   input  wire         rst_in,
   input  wire [W-1:0] d_in,
   output reg  [W-1:0] q_out
);
   reg [W-1:0] meta;
   always @(posedge mclk_in) begin
      if (rst_in) begin
         meta  <= {W{1'b0}};
         q_out <= {W{1'b0}};
      end else begin
         meta  <= d_in;
         q_out <= meta;
      end
   end
endmodule // pfs_sync2
